// ### rtl/lcsb_pkg.sv
// package: register map, timing counts and types of the local control bank
package lcsb_pkg;
   localparam int NUM_SW = 16; // local control switches and local bits
   localparam int DATA_W = 32; // register data width
   localparam int CNT_W = 25; // wide enough for two seconds of cycles
   // register offsets, word addressed
   localparam logic [3:0] REG_LABEL_EN = 4'h0; // switches with labels set
   localparam logic [3:0] REG_SW_TYPE = 4'h1; // two type bits per switch
   localparam logic [3:0] REG_ROT_EN = 4'h2; // enabled rotating items
   localparam logic [3:0] REG_TEST_SEL = 4'h3; // contact for output test
   localparam logic [3:0] REG_LOCAL = 4'h4; // local bits, read only
   localparam logic [3:0] REG_MENU = 4'h5; // menu status, read only
   // field positions
   localparam int MENU_IDX_LSB = 0; // cursor in menu status
   localparam int MENU_ST_LSB = 4; // state code in menu status
   // reset values
   localparam logic [15:0] LABEL_EN_RST = 16'h0000;
   localparam logic [31:0] SW_TYPE_RST = 32'h0000_0000;
   localparam logic [15:0] ROT_EN_RST = 16'h0000;
   localparam logic [3:0] TEST_SEL_RST = 4'h0;
   localparam logic [15:0] LOCAL_RST = 16'h0000;
   // timing
   localparam longint CLK_HZ = 10_000_000; // sys_clk rate
   localparam longint SHOW_MS = 2000; // display hold and rotation step
   localparam longint TEST_MS = 1000; // front panel contact pulse
   localparam int SHOW_CYC = int'((CLK_HZ * SHOW_MS) / 1000);
   localparam int TEST_CYC = int'((CLK_HZ * TEST_MS) / 1000);

   typedef logic [CNT_W-1:0] lcsb_cnt_t;
   // switch behaviour, two bits per switch in the type register
   typedef enum logic [1:0] {
      SWT_ONOFF = 2'h0,
      SWT_OFFMOM = 2'h1,
      SWT_THREE = 2'h2
   } lcsb_swtype_t;
   // switch position as shown and requested
   typedef enum logic [1:0] {
      POS_OFF = 2'h0,
      POS_ON = 2'h1,
      POS_MOM = 2'h2
   } lcsb_pos_t;
   // front panel menu, one-hot
   typedef enum logic [4:0] {
      ST_DEFAULT = 5'h01,
      ST_SWITCH = 5'h02,
      ST_TEST = 5'h04,
      ST_CONFIRM = 5'h08,
      ST_TESTRUN = 5'h10
   } lcsb_state_t;
   // what the display shows
   typedef enum logic [2:0] {
      DSP_NAME = 3'h0,
      DSP_PROMPT = 3'h1,
      DSP_ITEM = 3'h2,
      DSP_SWITCH = 3'h3,
      DSP_CONFIRM = 3'h4,
      DSP_TEST = 3'h5
   } lcsb_dkind_t;
   // debounced one-cycle pushbutton presses
   typedef struct packed {
      logic control;
      logic right;
      logic select;
      logic yes;
      logic no;
      logic leave;
   } lcsb_buttons_t;
   // display request
   typedef struct packed {
      lcsb_dkind_t kind;
      logic [4:0] index;
      lcsb_pos_t pos;
   } lcsb_display_t;
   localparam lcsb_display_t DISP_RST = '{kind: DSP_NAME, index: 5'h00,
                                          pos: POS_OFF};
endpackage : lcsb_pkg

// ### rtl/lcsb_top.sv
// module: front panel local control switch bank with rotating display
// Behaviour
// RULE1 - sixteen local bits, settable and clearable
// RULE2 - local bits exported as logic inputs
// RULE3 - per switch: on/off, off/mom, three-position
// RULE4 - only labelled switches exist and appear
// RULE5 - momentary bit high one processing interval
// RULE6 - momentary position shown two seconds
// RULE7 - control press shows first configured switch
// RULE8 - right arrow: next switch, test, wrap
// RULE9 - select asks confirm; yes changes position
// RULE10 - local bits restored from nonvolatile memory
// RULE11 - device name when nothing else shown
// RULE12 - control prompt shown when switches exist
// RULE13 - prompt then enabled items, two seconds each
// RULE14 - panel contact test pulses one second
// RULE15 - panel only, no password, no serial
// RULE16 - declining confirm changes nothing
// RULE17 - bit changes land on interval boundaries
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module lcsb_top #(
   parameter int SHOW_CYCLES = lcsb_pkg::SHOW_CYC, // two second hold
   parameter int TEST_CYCLES = lcsb_pkg::TEST_CYC // one second pulse
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire lcsb_pkg::lcsb_buttons_t buttons,
   input wire logic proc_tick,
   input wire logic nv_restore_valid,
   input wire logic [15:0] nv_restore_bits,
   output logic nv_store_strobe,
   output logic [15:0] local_bits,
   output lcsb_pkg::lcsb_display_t disp,
   output logic contact_test_pulse,
   output logic [3:0] contact_test_sel
);
   // lowest set bit of mask at or above lo, with a found flag on top
   function automatic logic [5:0] lcsb_scan(input logic [16:0] mask,
                                            input logic [4:0] lo);
      logic [5:0] res;
      res = 6'h00;
      for (int i = 16; i >= 0; i--)
         if (mask[i] && (5'(i) >= lo))
            res = {1'b1, 5'(i)};
      return res;
   endfunction : lcsb_scan

   // settings written by software; none of them writes the bits, which change only through a confirmed menu change or a nonvolatile restore
   logic [15:0] label_en, next_label_en; // labelled switches
   logic [31:0] sw_type, next_sw_type; // two bits per switch
   logic [15:0] rot_en, next_rot_en; // rotating display items
   logic [3:0] test_sel, next_test_sel; // contact for panel test
   logic [31:0] next_rdata;
   // menu
   lcsb_pkg::lcsb_state_t state, next_state;
   logic [3:0] cur_idx, next_cur_idx; // displayed switch
   logic req_valid, next_req_valid; // change waiting for boundary
   logic [3:0] req_idx, next_req_idx;
   lcsb_pkg::lcsb_pos_t req_pos, next_req_pos;
   lcsb_pkg::lcsb_cnt_t test_cnt, next_test_cnt;
   logic next_test_pulse;
   logic [3:0] next_test_out;
   // bits
   logic [15:0] next_bits;
   logic mom_active, next_mom_active; // momentary bit to drop
   logic [3:0] mom_idx, next_mom_idx;
   lcsb_pkg::lcsb_cnt_t show_cnt, next_show_cnt; // momentary display
   logic [3:0] show_idx, next_show_idx;
   logic next_nv_strobe;
   // display
   logic [4:0] rot_slot, next_rot_slot; // 0 prompt, k+1 item k
   lcsb_pkg::lcsb_cnt_t rot_cnt, next_rot_cnt;
   lcsb_pkg::lcsb_display_t next_disp;
   // helpers
   logic any_cfg; // at least one switch exists
   logic [5:0] first_cfg, after_cur; // scan results over switches
   logic [16:0] rot_mask; // prompt plus enabled items
   logic [5:0] rot_next, rot_first;
   lcsb_pkg::lcsb_swtype_t cur_type;
   lcsb_pkg::lcsb_pos_t cur_pos, target_pos;

   // switch lookup shared by menu and display
   always_comb
   begin
      any_cfg = |label_en; // [RULE4]
      first_cfg = lcsb_scan({1'b0, label_en}, 5'h00);
      after_cur = lcsb_scan({1'b0, label_en}, {1'b0, cur_idx} + 5'h01);
      rot_mask = {rot_en, any_cfg}; // [RULE12]
      rot_first = lcsb_scan(rot_mask, 5'h00);
      rot_next = lcsb_scan(rot_mask, rot_slot + 5'h01);
      cur_type = lcsb_pkg::lcsb_swtype_t'(sw_type[{cur_idx, 1'b0} +: 2]);
      // a momentary operation stays on show for the hold time
      if ((show_cnt != '0) && (show_idx == cur_idx))
         cur_pos = lcsb_pkg::POS_MOM; // [RULE6]
      else if (local_bits[cur_idx])
         cur_pos = lcsb_pkg::POS_ON;
      else
         cur_pos = lcsb_pkg::POS_OFF;
      // position proposed by the operate confirmation
      case (cur_type) // [RULE3]
         lcsb_pkg::SWT_ONOFF:
            target_pos = local_bits[cur_idx] ? lcsb_pkg::POS_OFF
                                              : lcsb_pkg::POS_ON;
         lcsb_pkg::SWT_OFFMOM:
            target_pos = lcsb_pkg::POS_MOM;
         lcsb_pkg::SWT_THREE:
            target_pos = local_bits[cur_idx] ? lcsb_pkg::POS_MOM
                                              : lcsb_pkg::POS_ON;
         default:
            target_pos = local_bits[cur_idx] ? lcsb_pkg::POS_OFF
                                              : lcsb_pkg::POS_ON;
      endcase
   end

   // register port: settings only, the bits are never writable here
   always_comb
   begin
      next_label_en = label_en;
      next_sw_type = sw_type;
      next_rot_en = rot_en;
      next_test_sel = test_sel;
      next_rdata = 32'h0000_0000; // data stand for one cycle only
      if (reg_wr)
      begin
         case (reg_addr)
            lcsb_pkg::REG_LABEL_EN: next_label_en = reg_wdata[15:0];
            lcsb_pkg::REG_SW_TYPE: next_sw_type = reg_wdata;
            lcsb_pkg::REG_ROT_EN: next_rot_en = reg_wdata[15:0];
            lcsb_pkg::REG_TEST_SEL: next_test_sel = reg_wdata[3:0];
            default: ; // read-only or unmapped: ignored
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            lcsb_pkg::REG_LABEL_EN: next_rdata = {16'h0000, label_en};
            lcsb_pkg::REG_SW_TYPE: next_rdata = sw_type;
            lcsb_pkg::REG_ROT_EN: next_rdata = {16'h0000, rot_en};
            lcsb_pkg::REG_TEST_SEL: next_rdata = {28'h0000000, test_sel};
            lcsb_pkg::REG_LOCAL: next_rdata = {16'h0000, local_bits};
            lcsb_pkg::REG_MENU:
               next_rdata = {23'h000000, state, cur_idx};
            default: next_rdata = 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end

   // settings registers
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         label_en <= lcsb_pkg::LABEL_EN_RST;
         sw_type <= lcsb_pkg::SW_TYPE_RST;
         rot_en <= lcsb_pkg::ROT_EN_RST;
         test_sel <= lcsb_pkg::TEST_SEL_RST;
         reg_rdata <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         label_en <= next_label_en;
         sw_type <= next_sw_type;
         rot_en <= next_rot_en;
         test_sel <= next_test_sel;
         reg_rdata <= next_rdata;
      end
   end

   // menu walk, driven by the pushbuttons alone, no password [RULE15]
   always_comb
   begin
      next_state = state;
      next_cur_idx = cur_idx;
      next_req_valid = req_valid;
      next_req_idx = req_idx;
      next_req_pos = req_pos;
      next_test_cnt = test_cnt;
      next_test_pulse = 1'b0;
      next_test_out = contact_test_sel;
      if (req_valid && proc_tick)
         next_req_valid = 1'b0; // cleared at the boundary; the bit logic takes it unless a restore lands this cycle
      case (state)
         lcsb_pkg::ST_DEFAULT:
            if (buttons.control && any_cfg)
            begin
               next_state = lcsb_pkg::ST_SWITCH; // [RULE7]
               next_cur_idx = first_cfg[3:0];
            end
         lcsb_pkg::ST_SWITCH:
            if (buttons.leave || !label_en[cur_idx])
               next_state = lcsb_pkg::ST_DEFAULT; // [RULE4]
            else if (buttons.right)
            begin
               if (after_cur[5])
                  next_cur_idx = after_cur[3:0]; // [RULE8]
               else
                  next_state = lcsb_pkg::ST_TEST; // [RULE8]
            end
            else if (buttons.select)
               next_state = lcsb_pkg::ST_CONFIRM; // [RULE9]
         lcsb_pkg::ST_CONFIRM:
            if (buttons.no || buttons.leave)
               next_state = lcsb_pkg::ST_SWITCH; // [RULE16]
            else if (buttons.yes && !req_valid)
            begin
               // one change in flight; a yes during it is ignored
               next_req_valid = 1'b1; // [RULE9]
               next_req_idx = cur_idx;
               next_req_pos = target_pos;
               next_state = lcsb_pkg::ST_SWITCH;
            end
         lcsb_pkg::ST_TEST:
            if (buttons.leave)
               next_state = lcsb_pkg::ST_DEFAULT;
            else if (buttons.right)
            begin
               next_state = any_cfg ? lcsb_pkg::ST_SWITCH
                                    : lcsb_pkg::ST_DEFAULT; // [RULE8]
               next_cur_idx = first_cfg[3:0];
            end
            else if (buttons.select)
            begin
               next_state = lcsb_pkg::ST_TESTRUN;
               next_test_cnt = '0;
               next_test_pulse = 1'b1; // [RULE14]
               next_test_out = test_sel;
            end
         lcsb_pkg::ST_TESTRUN:
            // the pulse always runs out; exit waits for it
            if (test_cnt == lcsb_pkg::lcsb_cnt_t'(TEST_CYCLES - 1))
               next_state = lcsb_pkg::ST_TEST; // [RULE14]
            else
            begin
               next_test_cnt = test_cnt + 1'b1;
               next_test_pulse = 1'b1;
            end
         default:
            next_state = lcsb_pkg::ST_DEFAULT;
      endcase
   end

   // menu registers
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state <= lcsb_pkg::ST_DEFAULT;
         cur_idx <= 4'h0;
         req_valid <= 1'b0;
         req_idx <= 4'h0;
         req_pos <= lcsb_pkg::POS_OFF;
         test_cnt <= '0;
         contact_test_pulse <= 1'b0;
         contact_test_sel <= lcsb_pkg::TEST_SEL_RST;
      end
      else if (clk_en)
      begin
         state <= next_state;
         cur_idx <= next_cur_idx;
         req_valid <= next_req_valid;
         req_idx <= next_req_idx;
         req_pos <= next_req_pos;
         test_cnt <= next_test_cnt;
         contact_test_pulse <= next_test_pulse;
         contact_test_sel <= next_test_out;
      end
   end

   // local bits change only on interval boundaries and restores [RULE17]
   always_comb
   begin
      next_bits = local_bits;
      next_mom_active = mom_active;
      next_mom_idx = mom_idx;
      next_show_idx = show_idx;
      next_show_cnt = (show_cnt != '0) ? show_cnt - 1'b1 : show_cnt;
      if (nv_restore_valid)
      begin
         next_bits = nv_restore_bits; // [RULE10]
         next_mom_active = 1'b0;
      end
      else if (proc_tick)
      begin
         // old momentary drops before a new change lands
         if (mom_active)
         begin
            next_bits[mom_idx] = 1'b0; // [RULE5]
            next_mom_active = 1'b0;
         end
         if (req_valid)
         begin
            next_bits[req_idx] = (req_pos != lcsb_pkg::POS_OFF); // [RULE1]
            if (req_pos == lcsb_pkg::POS_MOM)
            begin
               next_mom_active = 1'b1; // [RULE5]
               next_mom_idx = req_idx;
               next_show_idx = req_idx;
               next_show_cnt = lcsb_pkg::lcsb_cnt_t'(SHOW_CYCLES - 1); // [RULE6]
            end
         end
      end
      // every change except a restore is offered to the nonvolatile store
      next_nv_strobe = !nv_restore_valid && (next_bits != local_bits);
   end

   // bit registers, read by the control equations outside [RULE2]
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         local_bits <= lcsb_pkg::LOCAL_RST;
         mom_active <= 1'b0;
         mom_idx <= 4'h0;
         show_cnt <= '0;
         show_idx <= 4'h0;
         nv_store_strobe <= 1'b0;
      end
      else if (clk_en)
      begin
         local_bits <= next_bits;
         mom_active <= next_mom_active;
         mom_idx <= next_mom_idx;
         show_cnt <= next_show_cnt;
         show_idx <= next_show_idx;
         nv_store_strobe <= next_nv_strobe;
      end
   end

   // rotating default display and menu screens
   always_comb
   begin
      next_rot_slot = rot_slot;
      next_rot_cnt = rot_cnt;
      next_disp = lcsb_pkg::DISP_RST;
      if (state != lcsb_pkg::ST_DEFAULT || !rot_mask[rot_slot])
      begin
         // restart the rotation at its first item
         next_rot_slot = rot_first[4:0];
         next_rot_cnt = '0;
      end
      else if (rot_cnt == lcsb_pkg::lcsb_cnt_t'(SHOW_CYCLES - 1))
      begin
         next_rot_slot = rot_next[5] ? rot_next[4:0]
                                     : rot_first[4:0]; // [RULE13]
         next_rot_cnt = '0;
      end
      else
         next_rot_cnt = rot_cnt + 1'b1;
      case (state)
         lcsb_pkg::ST_DEFAULT:
            if (rot_mask == 17'h00000)
               next_disp.kind = lcsb_pkg::DSP_NAME; // [RULE11]
            else if (rot_slot == 5'h00)
               next_disp.kind = lcsb_pkg::DSP_PROMPT; // [RULE12]
            else
            begin
               next_disp.kind = lcsb_pkg::DSP_ITEM; // [RULE13]
               next_disp.index = rot_slot - 5'h01;
            end
         lcsb_pkg::ST_SWITCH:
         begin
            next_disp.kind = lcsb_pkg::DSP_SWITCH;
            next_disp.index = {1'b0, cur_idx};
            next_disp.pos = cur_pos; // [RULE6]
         end
         lcsb_pkg::ST_CONFIRM:
         begin
            next_disp.kind = lcsb_pkg::DSP_CONFIRM;
            next_disp.index = {1'b0, cur_idx};
            next_disp.pos = target_pos;
         end
         lcsb_pkg::ST_TEST, lcsb_pkg::ST_TESTRUN:
         begin
            next_disp.kind = lcsb_pkg::DSP_TEST;
            next_disp.index = {1'b0, test_sel};
         end
         default:
            next_disp.kind = lcsb_pkg::DSP_NAME;
      endcase
   end

   // display registers
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         rot_slot <= 5'h00;
         rot_cnt <= '0;
         disp <= lcsb_pkg::DISP_RST;
      end
      else if (clk_en)
      begin
         rot_slot <= next_rot_slot;
         rot_cnt <= next_rot_cnt;
         disp <= next_disp;
      end
   end

   // checks, paused while the clock enable is low
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n || !clk_en);

   property p_bits_on_tick;
      $changed(local_bits) |-> $past(proc_tick) || $past(nv_restore_valid);
   endproperty
   a_bits_on_tick: assert property (p_bits_on_tick) // [RULE17]
      else $error("local bits changed off a boundary");
   property p_mom_one_interval;
      proc_tick && !nv_restore_valid && req_valid
         && req_pos == lcsb_pkg::POS_MOM
      |=> local_bits[$past(req_idx)] && mom_active;
   endproperty
   a_mom_one_interval: assert property (p_mom_one_interval) // [RULE5]
      else $error("momentary bit not raised for its interval");
   // held in between by the boundary check; the next boundary drops it
   property p_mom_drop;
      proc_tick && !nv_restore_valid && mom_active && !req_valid
      |=> !local_bits[$past(mom_idx)] && !mom_active;
   endproperty
   a_mom_drop: assert property (p_mom_drop) // [RULE5]
      else $error("momentary bit held past one interval");
   property p_change_needs_yes;
      $rose(req_valid) |-> $past(state == lcsb_pkg::ST_CONFIRM && buttons.yes);
   endproperty
   a_change_needs_yes: assert property (p_change_needs_yes) // [RULE9]
      else $error("switch change without confirmation");
   property p_decline;
      state == lcsb_pkg::ST_CONFIRM && buttons.no
      |=> state == lcsb_pkg::ST_SWITCH && !$rose(req_valid) && $stable(cur_idx);
   endproperty
   a_decline: assert property (p_decline) // [RULE16]
      else $error("declined confirmation changed state");
   property p_enter_first;
      state == lcsb_pkg::ST_DEFAULT && buttons.control && any_cfg
      |=> state == lcsb_pkg::ST_SWITCH && cur_idx == $past(first_cfg[3:0]);
   endproperty
   a_enter_first: assert property (p_enter_first) // [RULE7]
      else $error("control press did not show first switch");
   property p_only_labelled;
      state == lcsb_pkg::ST_SWITCH && $stable(label_en) |-> label_en[cur_idx];
   endproperty
   a_only_labelled: assert property (p_only_labelled) // [RULE4]
      else $error("unlabelled switch displayed");
   property p_wrap;
      state == lcsb_pkg::ST_TEST && buttons.right && any_cfg && !buttons.leave
      |=> state == lcsb_pkg::ST_SWITCH && cur_idx == $past(first_cfg[3:0]);
   endproperty
   a_wrap: assert property (p_wrap) // [RULE8]
      else $error("right arrow did not wrap to first switch");
   property p_test_len;
      contact_test_pulse && test_cnt == lcsb_pkg::lcsb_cnt_t'(TEST_CYCLES - 1)
      |=> !contact_test_pulse && state == lcsb_pkg::ST_TEST;
   endproperty
   a_test_len: assert property (p_test_len) // [RULE14]
      else $error("contact test pulse wrong length");
   property p_name;
      state == lcsb_pkg::ST_DEFAULT && rot_mask == 17'h00000
      |=> disp.kind == lcsb_pkg::DSP_NAME;
   endproperty
   a_name: assert property (p_name) // [RULE11]
      else $error("device name not shown");
   c_mom: cover property (proc_tick && req_valid
                          && req_pos == lcsb_pkg::POS_MOM);
   c_decline: cover property (state == lcsb_pkg::ST_CONFIRM && buttons.no);
   c_test: cover property ($fell(contact_test_pulse));
   c_rotate: cover property (state == lcsb_pkg::ST_DEFAULT
                             && rot_cnt == '0 && rot_slot != 5'h00);
endmodule : lcsb_top

// ### dv/lcsb_operator.sv
// operator model: presses one debounced front panel button on request
`timescale 1ns/10ps
module lcsb_operator (
   input wire logic sys_clk,
   input wire logic go,
   input wire lcsb_pkg::lcsb_buttons_t want,
   output lcsb_pkg::lcsb_buttons_t buttons
);
   // one-cycle press; nothing held, so no button ever looks stuck
   always_ff @(posedge sys_clk)
      buttons <= go ? want : '0;
endmodule : lcsb_operator

// ### dv/tb_top.sv
// testbench: hand-written scenarios for the local control switch bank
`timescale 1ns/10ps
module tb_top;
   localparam int SHOW = 20; // shortened two second hold
   localparam int TEST = 10; // shortened one second pulse
   logic sys_clk = 1'b0; // 10 MHz
   logic reset_n = 1'b0;
   logic clk_en = 1'b1; // freezes the design while low
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic go = 1'b0; // operator press request
   lcsb_pkg::lcsb_buttons_t want = '0;
   lcsb_pkg::lcsb_buttons_t buttons;
   logic proc_tick = 1'b0;
   logic nv_restore_valid = 1'b0;
   logic [15:0] nv_restore_bits = 16'h0;
   logic nv_store_strobe;
   logic [15:0] local_bits;
   lcsb_pkg::lcsb_display_t disp;
   logic contact_test_pulse;
   logic [3:0] contact_test_sel;
   int fail_count = 0;
   int check_count = 0;
   int n; // run length counter
   // design under test, short counts keep the run brief
   lcsb_top #(.SHOW_CYCLES(SHOW), .TEST_CYCLES(TEST)) uut (
      .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .buttons(buttons),
      .proc_tick(proc_tick), .nv_restore_valid(nv_restore_valid),
      .nv_restore_bits(nv_restore_bits), .nv_store_strobe(nv_store_strobe),
      .local_bits(local_bits), .disp(disp),
      .contact_test_pulse(contact_test_pulse),
      .contact_test_sel(contact_test_sel));
   // front panel operator
   lcsb_operator op (.sys_clk(sys_clk), .go(go), .want(want),
      .buttons(buttons));
   // clock source
   initial
      forever #50 sys_clk = ~sys_clk;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task final_report;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task rdc(input logic [3:0] a, input logic [31:0] e);
      @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rdc
   // press, then let the menu and display settle
   task press(input logic [5:0] b);
      @(posedge sys_clk) {go, want} <= {1'b1, b};
      @(posedge sys_clk) go <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : press
   // one interval boundary; returns one cycle after the bits update
   task tick;
      @(posedge sys_clk) proc_tick <= 1'b1;
      @(posedge sys_clk) proc_tick <= 1'b0;
      @(posedge sys_clk) #1;
   endtask : tick
   task dchk(input logic [2:0] k, input logic [4:0] i);
      chk({27'h0, disp.kind, disp.index}, {27'h0, k, i});
   endtask : dchk
   task t_reset;
      rdc(lcsb_pkg::REG_LABEL_EN, 32'h0);
      rdc(lcsb_pkg::REG_LOCAL, 32'h0);
      rdc(4'hf, 32'h0); // unmapped place reads zero
      dchk(lcsb_pkg::DSP_NAME, 5'h0);
      press(6'h20); // control with no switch configured
      rdc(lcsb_pkg::REG_MENU, 32'h10);
   endtask : t_reset
   task t_menu;
      wr(lcsb_pkg::REG_LABEL_EN, 32'h5); // switches 0 and 2 exist
      wr(lcsb_pkg::REG_SW_TYPE, 32'h1); // 0 off/mom, 2 on/off
      wr(lcsb_pkg::REG_TEST_SEL, 32'h9);
      repeat (SHOW + 3) @(posedge sys_clk);
      #1 dchk(lcsb_pkg::DSP_PROMPT, 5'h0);
      press(6'h20);
      dchk(lcsb_pkg::DSP_SWITCH, 5'h0);
      press(6'h10);
      dchk(lcsb_pkg::DSP_SWITCH, 5'h2);
      press(6'h10);
      chk(32'(disp.kind), 32'(lcsb_pkg::DSP_TEST));
      press(6'h10);
      dchk(lcsb_pkg::DSP_SWITCH, 5'h0);
   endtask : t_menu
   task t_moment;
      press(6'h08);
      chk(32'(disp.kind), 32'(lcsb_pkg::DSP_CONFIRM));
      press(6'h02);
      tick;
      dchk(lcsb_pkg::DSP_SWITCH, 5'h0);
      chk(32'(local_bits), 32'h0);
      press(6'h08);
      press(6'h04);
      chk(32'(local_bits), 32'h0);
      tick;
      chk(32'(local_bits), 32'h1);
      chk(32'(disp.pos), 32'(lcsb_pkg::POS_MOM));
      tick;
      chk(32'(local_bits), 32'h0);
      repeat (SHOW) @(posedge sys_clk);
      #1 chk(32'(disp.pos), 32'(lcsb_pkg::POS_OFF));
   endtask : t_moment
   task t_toggle;
      press(6'h10);
      press(6'h08);
      press(6'h04);
      @(posedge sys_clk) proc_tick <= 1'b1;
      @(posedge sys_clk) proc_tick <= 1'b0;
      // store strobe stands in the same cycle as the new bits
      #1 chk(32'(nv_store_strobe), 32'h1);
      chk(32'(local_bits), 32'h4);
      @(posedge sys_clk) #1 chk(32'(nv_store_strobe), 32'h0);
      rdc(lcsb_pkg::REG_LOCAL, 32'h4);
      wr(lcsb_pkg::REG_SW_TYPE, 32'h21); // switch 2 now three-position
      press(6'h08);
      chk(32'(disp.pos), 32'(lcsb_pkg::POS_MOM));
      press(6'h04);
      tick;
      chk(32'(local_bits), 32'h4);
      tick;
      chk(32'(local_bits), 32'h0);
   endtask : t_toggle
   task t_test;
      press(6'h10);
      @(posedge sys_clk) {go, want} <= {1'b1, 6'h08};
      @(posedge sys_clk) go <= 1'b0;
      n = 0;
      repeat (TEST + 8) @(negedge sys_clk) n += int'(contact_test_pulse);
      chk(32'(n), 32'(TEST));
      chk(32'(contact_test_sel), 32'h9);
   endtask : t_test
   task t_rotate;
      press(6'h01); // back to default display
      wr(lcsb_pkg::REG_ROT_EN, 32'h1);
      n = 0;
      while (disp.kind !== lcsb_pkg::DSP_ITEM && n < 3 * SHOW)
         @(negedge sys_clk) n++;
      n = 0;
      while (disp.kind === lcsb_pkg::DSP_ITEM && n < 3 * SHOW)
         @(negedge sys_clk) n++;
      chk(32'(n), 32'(SHOW));
      chk(32'(disp.kind), 32'(lcsb_pkg::DSP_PROMPT));
   endtask : t_rotate
   // power cycle: bits come back only through the stored copy
   task t_restore;
      @(posedge sys_clk) reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk) #1 chk(32'(local_bits), 32'h0);
      @(posedge sys_clk) {nv_restore_valid, nv_restore_bits} <= 17'h18001;
      @(posedge sys_clk) nv_restore_valid <= 1'b0;
      #1 chk(32'(local_bits), 32'h8001);
      // a restore offered while frozen must not land
      @(posedge sys_clk)
         {clk_en, nv_restore_valid, nv_restore_bits} <= 18'h10000;
      @(posedge sys_clk) {clk_en, nv_restore_valid} <= 2'b10;
      #1 chk(32'(local_bits), 32'h8001);
   endtask : t_restore
   // main sequence
   initial
   begin
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset;
      t_menu;
      t_moment;
      t_toggle;
      t_test;
      t_rotate;
      t_restore;
      final_report;
   end
   // watchdog, far beyond the few hundred cycles the scenarios need
   initial
   begin
      #(3000 * 100);
      fail_count++;
      final_report;
   end
endmodule : tb_top
